// ==== cms_host_model.sv ====
// host cpus sitting on the four request lanes of the block
`timescale 1ns/10ps
`default_nettype none
module cms_host_model (
    // clock
    input  wire logic                                    ref_clk_i,
    // request lanes
    output logic [cms_pkg::HOSTS-1:0]                    req_o,
    output logic [cms_pkg::HOSTS-1:0]                    we_o,
    output logic [cms_pkg::HOSTS-1:0][cms_pkg::RSEL_W-1:0] sel_o,
    output logic [cms_pkg::HOSTS-1:0][cms_pkg::DW-1:0]   wdata_o,
    // answers
    input  wire logic [cms_pkg::HOSTS-1:0]               rvalid_i,
    input  wire logic [cms_pkg::HOSTS-1:0][cms_pkg::DW-1:0] rdata_i
);
    import cms_pkg::*;
    logic [HOSTS-1:0][DW:0] ans;

    initial begin
        req_o = '0;
        we_o = '0;
        sel_o = '0;
        wdata_o = '0;
    end

    // stage one lane; nothing is requested until fire
    task automatic stage(input int h, input logic w, input cms_reg_e s,
                         input logic [DW-1:0] d);
        we_o[h] = w;
        sel_o[h] = s;
        wdata_o[h] = d;
    endtask

    // one-cycle strobe on all masked lanes, answers caught next edge
    task automatic fire(input logic [HOSTS-1:0] m);
        @(posedge ref_clk_i);
        #1;
        req_o = m;
        @(posedge ref_clk_i);
        #1;
        req_o = '0;
        for (int h = 0; h < HOSTS; h++) begin
            ans[h] = {rvalid_i[h], rdata_i[h]};
        end
        // idle lanes must not keep showing the last value
        we_o = ~we_o;
        wdata_o = ~wdata_o;
    endtask

    // release by writing one to the take field
    task automatic rel(input int h, input cms_reg_e s);
        stage(h, 1'b1, s, ONE_W);
        fire(4'h1 << h);
    endtask
endmodule
`default_nettype wire

// ==== cms_lock.sv ====
// one hardware lock: take by read, release by write of one
`timescale 1ns/10ps
`default_nettype none
module cms_lock #(
    parameter int unsigned HOSTS = cms_pkg::HOSTS
) (
    // clock and reset
    input  wire logic               ref_clk_i,
    input  wire logic               rst_b_i,
    // requests
    input  wire logic [HOSTS-1:0]   take_rd_i,
    input  wire logic               release_i,
    // state
    output logic [HOSTS-1:0]        grant_o,
    output logic                    held_o,
    output cms_pkg::cms_holder_t    holder_o
);
    import cms_pkg::*;

    cms_lock_e   state_q;
    cms_lock_e   state_d;
    cms_holder_t holder_q;
    cms_holder_t holder_d;
    logic [HOSTS-1:0] first;

    // lowest index wins a same-cycle race
    assign first = take_rd_i & (~take_rd_i + HOSTS'(1));

    function automatic cms_holder_t code_of(input logic [HOSTS-1:0] oh);
        cms_holder_t c;
        c = HOLD_FREE;
        for (int i = 0; i < HOSTS; i++) begin
            if (oh[i]) begin
                c = HOLD_BASE + HOLD_W'(i);
            end
        end
        return c;
    endfunction

    assign grant_o = (state_q == LOCK_FREE) ? first : '0;

    always_comb begin
        state_d  = state_q;
        holder_d = holder_q;
        case (state_q)
            LOCK_FREE: begin
                if (|take_rd_i) begin
                    state_d  = LOCK_HELD;
                    holder_d = code_of(first);
                end
            end
            LOCK_HELD: begin
                // any host may release; reads here answer zero
                if (release_i) begin
                    state_d  = LOCK_FREE;
                    holder_d = HOLD_FREE;
                end
            end
            default: begin
                state_d  = LOCK_FREE;
                holder_d = HOLD_FREE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_q  <= LOCK_FREE;
            holder_q <= HOLD_FREE;
        end else begin
            state_q  <= state_d;
            holder_q <= holder_d;
        end
    end

    assign held_o   = (state_q == LOCK_HELD);
    assign holder_o = holder_q;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);

    chk_single_grant: assert property ($onehot0(grant_o))
        else $error("more than one take granted");
    chk_held_refuses: assert property (held_o |-> grant_o == '0)
        else $error("held lock granted again");
    chk_take_records: assert property (
        |grant_o |=> held_o && holder_o == code_of($past(grant_o)))
        else $error("take did not record holder");
    chk_hold_stable: assert property (
        held_o && !release_i |=> held_o && $stable(holder_o))
        else $error("holder changed without release");
    chk_release_frees: assert property (
        held_o && release_i |=> !held_o && holder_o == HOLD_FREE)
        else $error("release did not free lock");
    chk_free_no_owner: assert property (
        !held_o |-> holder_o == HOLD_FREE)
        else $error("free lock shows a holder");
endmodule
`default_nettype wire

// ==== cms_pkg.sv ====
// shared constants and types for the mailbox and lock block
package cms_pkg;
    localparam int unsigned HOSTS   = 4;
    localparam int unsigned DW      = 32;
    localparam int unsigned LOCKS   = 2;
    localparam int unsigned RSEL_W  = 4;
    localparam int unsigned HOLD_W  = 3;
    localparam int unsigned TAKE_BIT = 0;

    // host interface indices; cpu also carries the pcie path
    localparam int unsigned HOST_CPU  = 0;
    localparam int unsigned HOST_PAR  = 1;
    localparam int unsigned HOST_SER  = 2;
    localparam int unsigned HOST_MGMT = 3;

    typedef enum logic [RSEL_W-1:0] {
        REG_MAILBOX  = 4'h0,
        REG_MBOX_SET = 4'h1,
        REG_MBOX_CLR = 4'h2,
        REG_IRQ_CFG  = 4'h3,
        REG_LOCK0    = 4'h4,
        REG_LOCK1    = 4'h5,
        REG_HOLD0    = 4'h6,
        REG_HOLD1    = 4'h7,
        REG_FORCE    = 4'h8,
        REG_ROUTE    = 4'h9
    } cms_reg_e;

    typedef enum logic [0:0] {
        LOCK_FREE = 1'b0,
        LOCK_HELD = 1'b1
    } cms_lock_e;

    typedef logic [HOLD_W-1:0] cms_holder_t;

    // holder code: free, else host index plus one
    localparam cms_holder_t HOLD_FREE = 3'h0;
    localparam cms_holder_t HOLD_BASE = 3'h1;

    localparam logic [DW-1:0]    MBOX_RST = 32'h0000_0000;
    localparam logic [LOCKS-1:0] CFG_RST  = 2'h0;
    localparam logic [DW-1:0]    ZERO_W   = 32'h0000_0000;
    localparam logic [DW-1:0]    ONE_W    = 32'h0000_0001;
endpackage

// ==== cms_top.sv ====
// mailbox, two locks and soft interrupt routing for several hosts
// Function
// - one 32-bit mailbox, readable and writable as a whole word
// - all hosts modify the mailbox atomically, same-cycle set/clear merge
// - clear-mask write clears the masked mailbox bits, except bits a same-cycle set-mask write sets
// - set-mask write sets exactly the masked mailbox bits
// - two independent locks, each with own take and holder view
// - holder recorded per host; cpu and pcie share one host port
// - take read of a free lock returns 1, takes it, records host
// - take read of a held lock returns 0, state and holder kept
// - after a take every read returns 0 until released, owner too
// - release accepted from any host, not only the holder
// - read-only holder field shows state and holding host
// - soft interrupt follows each lock's free or taken state
// - polarity field selects free or taken as asserting state
// - lock zero drives soft irq zero, lock one soft irq one
// - manual trigger register asserts either soft irq directly
// - each soft irq routed to internal cpu or external output
`timescale 1ns/10ps
`default_nettype none
module cms_top #(
    parameter int unsigned HOSTS = cms_pkg::HOSTS
) (
    // clock and reset
    input  wire logic                              ref_clk_i,
    input  wire logic                              rst_b_i,
    // host request ports, one lane per host
    input  wire logic [HOSTS-1:0]                  host_req_i,
    input  wire logic [HOSTS-1:0]                  host_we_i,
    input  wire logic [HOSTS-1:0][cms_pkg::RSEL_W-1:0] host_reg_i,
    input  wire logic [HOSTS-1:0][cms_pkg::DW-1:0] host_wdata_i,
    // host answers
    output logic [HOSTS-1:0]                       host_rvalid_o,
    output logic [HOSTS-1:0][cms_pkg::DW-1:0]      host_rdata_o,
    // soft interrupts
    output logic [cms_pkg::LOCKS-1:0]              soft_irq_cpu_o,
    output logic [cms_pkg::LOCKS-1:0]              soft_irq_ext_o
);
    import cms_pkg::*;

    function automatic logic hit(input logic req,
                                 input logic [RSEL_W-1:0] sel,
                                 input cms_reg_e r);
        return req && (sel == r);
    endfunction

    // stored state
    logic [DW-1:0]    mbox_q;
    logic [DW-1:0]    mbox_d;
    logic [LOCKS-1:0] pol_q;
    logic [LOCKS-1:0] pol_d;
    logic [LOCKS-1:0] force_q;
    logic [LOCKS-1:0] force_d;
    logic [LOCKS-1:0] route_q;
    logic [LOCKS-1:0] route_d;

    // per-host decode
    logic [HOSTS-1:0]          wr_mbox;
    logic [HOSTS-1:0]          wr_set;
    logic [HOSTS-1:0]          wr_clr;
    logic [HOSTS-1:0]          wr_pol;
    logic [HOSTS-1:0]          wr_force;
    logic [HOSTS-1:0]          wr_route;
    logic [LOCKS-1:0][HOSTS-1:0] take_rd;
    logic [LOCKS-1:0][HOSTS-1:0] rel_wr;
    logic [LOCKS-1:0][HOSTS-1:0] grant;
    logic [LOCKS-1:0]          held;
    cms_holder_t               holder [LOCKS];
    logic [LOCKS-1:0]          release_any;
    logic [HOSTS-1:0][DW-1:0]  rd_word;

    // merged write effects
    logic [DW-1:0]    set_all;
    logic [DW-1:0]    clr_all;
    logic [DW-1:0]    base_w;
    logic [LOCKS-1:0] irq_lvl;

    genvar h;
    genvar s;
    generate
        for (h = 0; h < HOSTS; h++) begin : g_dec
            wire logic wreq = host_req_i[h] && host_we_i[h];
            wire logic rreq = host_req_i[h] && !host_we_i[h];
            assign wr_mbox[h]  = hit(wreq, host_reg_i[h], REG_MAILBOX);
            assign wr_set[h]   = hit(wreq, host_reg_i[h], REG_MBOX_SET);
            assign wr_clr[h]   = hit(wreq, host_reg_i[h], REG_MBOX_CLR);
            assign wr_pol[h]   = hit(wreq, host_reg_i[h], REG_IRQ_CFG);
            assign wr_force[h] = hit(wreq, host_reg_i[h], REG_FORCE);
            assign wr_route[h] = hit(wreq, host_reg_i[h], REG_ROUTE);
            assign take_rd[0][h] = hit(rreq, host_reg_i[h], REG_LOCK0);
            assign take_rd[1][h] = hit(rreq, host_reg_i[h], REG_LOCK1);
            // a zero in the take field is no release
            assign rel_wr[0][h] = hit(wreq, host_reg_i[h], REG_LOCK0)
                && host_wdata_i[h][TAKE_BIT];
            assign rel_wr[1][h] = hit(wreq, host_reg_i[h], REG_LOCK1)
                && host_wdata_i[h][TAKE_BIT];
        end
    endgenerate

    // set and clear masks from all hosts merge in one step
    always_comb begin
        set_all = ZERO_W;
        clr_all = ZERO_W;
        base_w  = mbox_q;
        pol_d   = pol_q;
        force_d = force_q;
        route_d = route_q;
        // lowest index wins plain writes, so loop downward
        for (int i = HOSTS - 1; i >= 0; i--) begin
            if (wr_set[i]) begin
                set_all = set_all | host_wdata_i[i];
            end
            if (wr_clr[i]) begin
                clr_all = clr_all | host_wdata_i[i];
            end
            if (wr_mbox[i]) begin
                base_w = host_wdata_i[i];
            end
            if (wr_pol[i]) begin
                pol_d = host_wdata_i[i][LOCKS-1:0];
            end
            if (wr_force[i]) begin
                force_d = host_wdata_i[i][LOCKS-1:0];
            end
            if (wr_route[i]) begin
                route_d = host_wdata_i[i][LOCKS-1:0];
            end
        end
        // set wins over clear on the same bit so no event is lost
        mbox_d = (base_w & ~clr_all) | set_all;
    end

    generate
        for (s = 0; s < LOCKS; s++) begin : g_lock
            assign release_any[s] = |rel_wr[s];
            cms_lock #(
                .HOSTS     (HOSTS)
            ) u_lock (
                .ref_clk_i (ref_clk_i),
                .rst_b_i   (rst_b_i),
                .take_rd_i (take_rd[s]),
                .release_i (release_any[s]),
                .grant_o   (grant[s]),
                .held_o    (held[s]),
                .holder_o  (holder[s])
            );
            // polarity zero: taken asserts; one: free asserts
            assign irq_lvl[s] = (held[s] ^ pol_q[s])
                | force_q[s];
        end
    endgenerate

    // read answer per host; writes answer with zero
    generate
        for (h = 0; h < HOSTS; h++) begin : g_rd
            always_comb begin
                rd_word[h] = ZERO_W;
                if (!host_we_i[h]) begin
                    case (host_reg_i[h])
                        REG_MAILBOX: rd_word[h] = mbox_q;
                        REG_IRQ_CFG: rd_word[h] = DW'(pol_q);
                        REG_LOCK0: begin
                            rd_word[h] = DW'(grant[0][h]);
                        end
                        REG_LOCK1: begin
                            rd_word[h] = DW'(grant[1][h]);
                        end
                        REG_HOLD0:   rd_word[h] = DW'(holder[0]);
                        REG_HOLD1:   rd_word[h] = DW'(holder[1]);
                        REG_FORCE:   rd_word[h] = DW'(force_q);
                        REG_ROUTE:   rd_word[h] = DW'(route_q);
                        default:     rd_word[h] = ZERO_W;
                    endcase
                end
            end
        end
    endgenerate

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mbox_q  <= MBOX_RST;
            pol_q   <= CFG_RST;
            force_q <= CFG_RST;
            route_q <= CFG_RST;
        end else begin
            mbox_q  <= mbox_d;
            pol_q   <= pol_d;
            force_q <= force_d;
            route_q <= route_d;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            host_rvalid_o <= '0;
            host_rdata_o  <= '0;
        end else begin
            host_rvalid_o <= host_req_i;
            host_rdata_o  <= rd_word;
        end
    end

    // route bit zero sends to the internal cpu, one to the pin
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            soft_irq_cpu_o <= '0;
            soft_irq_ext_o <= '0;
        end else begin
            soft_irq_cpu_o <= irq_lvl & ~route_q;
            soft_irq_ext_o <= irq_lvl & route_q;
        end
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);

    sequence s_set_write;
        |wr_set;
    endsequence

    sequence s_clr_write;
        |wr_clr && !(|wr_set);
    endsequence

    // a take read that finds lock zero free
    sequence s_take0_free;
        !held[0] && |take_rd[0];
    endsequence

    // owner reads lock zero again; must not be granted twice
    sequence s_owner_rereads;
        held[0] && take_rd[0][HOST_SER];
    endsequence

    chk_mbox_set: assert property (
        s_set_write |=>
        (mbox_q & $past(set_all)) == $past(set_all))
        else $error("set mask bit not set");
    chk_mbox_clr: assert property (
        s_clr_write |=> (mbox_q & $past(clr_all)) == ZERO_W)
        else $error("clear mask bit still set");
    chk_mbox_others: assert property (
        !(|wr_mbox) && (|wr_set || |wr_clr) |=>
        ((mbox_q ^ $past(mbox_q)) & ~$past(set_all | clr_all))
        == ZERO_W)
        else $error("unmasked mailbox bit changed");
    chk_mbox_plain: assert property (
        wr_mbox[HOST_CPU] && !(|wr_set) && !(|wr_clr) |=>
        mbox_q == $past(host_wdata_i[HOST_CPU]))
        else $error("plain mailbox write lost");
    chk_take_answer: assert property (
        grant[0][HOST_SER] |=> host_rvalid_o[HOST_SER]
        && host_rdata_o[HOST_SER] == ONE_W)
        else $error("granted take did not read one");
    chk_take_lock1: assert property (
        grant[1][HOST_MGMT] |=> host_rdata_o[HOST_MGMT] == ONE_W)
        else $error("lock one take did not read one");
    chk_take_marks: assert property (
        s_take0_free |=> held[0] && holder[0] != HOLD_FREE)
        else $error("take read left lock free");
    chk_owner_reread: assert property (
        s_owner_rereads |=> host_rdata_o[HOST_SER] == ZERO_W)
        else $error("owner read of held lock returned nonzero");
    chk_held_answer: assert property (
        held[1] && take_rd[1][HOST_PAR] |=>
        host_rdata_o[HOST_PAR] == ZERO_W)
        else $error("held lock read returned nonzero");
    chk_race_loser: assert property (
        !held[0] && take_rd[0][HOST_PAR] && take_rd[0][HOST_SER] |=>
        host_rdata_o[HOST_SER] == ZERO_W)
        else $error("race loser read one");
    chk_release_any: assert property (
        held[0] && rel_wr[0][HOST_CPU] |=>
        !held[0] && holder[0] == HOLD_FREE)
        else $error("release from a non-holder ignored");
    chk_zero_no_release: assert property (
        held[0] && !release_any[0] |=> held[0])
        else $error("lock freed without release");
    chk_zero_write_kept: assert property (
        held[1] && !release_any[1] |=> held[1] && $stable(holder[1]))
        else $error("zero write changed a held lock");
    chk_free_release: assert property (
        !held[0] && release_any[0] && !(|take_rd[0]) |=>
        !held[0] && holder[0] == HOLD_FREE)
        else $error("release of free lock changed it");
    chk_irq_route: assert property (
        ##1 soft_irq_cpu_o == $past(irq_lvl & ~route_q)
        && soft_irq_ext_o == $past(irq_lvl & route_q))
        else $error("soft irq routing wrong");
    chk_irq_ext_only: assert property (
        route_q[1] |=> !soft_irq_cpu_o[1])
        else $error("externally routed irq reached the cpu");
    chk_irq_force: assert property (
        force_q[0] |=> soft_irq_cpu_o[0] || soft_irq_ext_o[0])
        else $error("forced irq not raised");
    chk_irq_polarity: assert property (
        !force_q[0] && !pol_q[0] && held[0] && $stable(route_q) |=>
        soft_irq_cpu_o[0] || soft_irq_ext_o[0])
        else $error("taken lock did not raise irq");
    chk_irq_free_pol: assert property (
        !force_q[1] && pol_q[1] && !held[1] |=>
        soft_irq_cpu_o[1] || soft_irq_ext_o[1])
        else $error("free lock did not raise irq");
    chk_irq_quiet: assert property (
        !force_q[0] && !pol_q[0] && !held[0] |=>
        !soft_irq_cpu_o[0] && !soft_irq_ext_o[0])
        else $error("free lock raised irq");
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// self-checking bench for the mailbox and lock block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import cms_pkg::*;
    logic                          ref_clk_i;
    logic                          rst_b_i;
    logic [HOSTS-1:0]              req;
    logic [HOSTS-1:0]              we;
    logic [HOSTS-1:0][RSEL_W-1:0]  sel;
    logic [HOSTS-1:0][DW-1:0]      wdata;
    logic [HOSTS-1:0]              rvalid;
    logic [HOSTS-1:0][DW-1:0]      rdata;
    logic [LOCKS-1:0]              irq_cpu;
    logic [LOCKS-1:0]              irq_ext;
    int                            failures;
    int                            tests_run;
    int                            cycles;

    cms_top #(.HOSTS(HOSTS)) u_cms_top (
        .ref_clk_i      (ref_clk_i),
        .rst_b_i        (rst_b_i),
        .host_req_i     (req),
        .host_we_i      (we),
        .host_reg_i     (sel),
        .host_wdata_i   (wdata),
        .host_rvalid_o  (rvalid),
        .host_rdata_o   (rdata),
        .soft_irq_cpu_o (irq_cpu),
        .soft_irq_ext_o (irq_ext)
    );

    cms_host_model u_cms_host_model (
        .ref_clk_i (ref_clk_i),
        .req_o     (req),
        .we_o      (we),
        .sel_o     (sel),
        .wdata_o   (wdata),
        .rvalid_i  (rvalid),
        .rdata_i   (rdata)
    );

    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    task automatic end_sim;
        $display("failures=%0d tests_run=%0d", failures, tests_run);
        if (failures == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [DW:0] seen, input logic [DW:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input int h, input cms_reg_e s,
                      input logic [DW-1:0] d);
        u_cms_host_model.stage(h, 1'b1, s, d);
        u_cms_host_model.fire(4'h1 << h);
    endtask

    // answer strobe and data are compared together
    task automatic rd(input int h, input cms_reg_e s,
                      input logic [DW-1:0] e);
        u_cms_host_model.stage(h, 1'b0, s, ZERO_W);
        u_cms_host_model.fire(4'h1 << h);
        chk(u_cms_host_model.ans[h], {1'b1, e});
    endtask

    // irq is registered after the state, so give it one more edge
    task automatic irq(input logic [1:0] c, input logic [1:0] x);
        @(posedge ref_clk_i);
        #1;
        chk({29'h0, irq_cpu, irq_ext}, {29'h0, c, x});
    endtask

    // hang guard, far above the hundred or so cycles the run needs
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            end_sim();
        end
    end

    initial begin
        failures = 0;
        tests_run = 0;
        cycles = 0;
        rst_b_i = 1'b0;
        repeat (20) @(posedge ref_clk_i);
        #1;
        rst_b_i = 1'b1;
        rd(0, REG_MAILBOX, 32'h0);
        rd(1, REG_HOLD0, 32'h0);
        irq(2'h0, 2'h0);
        wr(0, REG_MAILBOX, 32'ha5a5_5a5a);
        rd(0, REG_MAILBOX, 32'ha5a5_5a5a);
        wr(1, REG_MBOX_SET, 32'h0000_00ff);
        rd(2, REG_MAILBOX, 32'ha5a5_5aff);
        wr(2, REG_MBOX_CLR, 32'hff00_0000);
        rd(3, REG_MAILBOX, 32'h00a5_5aff);
        // three hosts modify the mailbox in one cycle
        u_cms_host_model.stage(0, 1'b1, REG_MBOX_SET, 32'h0000_0f00);
        u_cms_host_model.stage(1, 1'b1, REG_MBOX_CLR, 32'h0000_00f0);
        u_cms_host_model.stage(3, 1'b1, REG_MBOX_SET, 32'h1000_0000);
        u_cms_host_model.fire(4'hb);
        rd(2, REG_MAILBOX, 32'h10a5_5f0f);
        // lock zero taken by the serial host
        rd(2, REG_LOCK0, 32'h1);
        rd(0, REG_HOLD0, 32'h3);
        rd(2, REG_LOCK0, 32'h0);
        rd(1, REG_LOCK0, 32'h0);
        rd(3, REG_HOLD0, 32'h3);
        rd(3, REG_LOCK1, 32'h1);
        rd(0, REG_HOLD1, 32'h4);
        irq(2'h3, 2'h0);
        wr(1, REG_LOCK1, ZERO_W);
        rd(0, REG_HOLD1, 32'h4);
        rd(1, REG_LOCK1, 32'h0);
        u_cms_host_model.rel(1, REG_LOCK1);
        rd(2, REG_HOLD1, 32'h0);
        irq(2'h1, 2'h0);
        wr(0, REG_IRQ_CFG, 32'h2);
        irq(2'h3, 2'h0);
        rd(1, REG_IRQ_CFG, 32'h2);
        wr(2, REG_ROUTE, 32'h2);
        irq(2'h1, 2'h2);
        rd(3, REG_ROUTE, 32'h2);
        u_cms_host_model.rel(0, REG_LOCK0);
        u_cms_host_model.rel(3, REG_LOCK0);
        rd(0, REG_HOLD0, 32'h0);
        irq(2'h0, 2'h2);
        wr(1, REG_IRQ_CFG, 32'h0);
        wr(1, REG_FORCE, 32'h1);
        irq(2'h1, 2'h0);
        rd(0, REG_FORCE, 32'h1);
        wr(1, REG_FORCE, 32'h0);
        irq(2'h0, 2'h0);
        // three hosts race for the free lock zero
        u_cms_host_model.stage(1, 1'b0, REG_LOCK0, ZERO_W);
        u_cms_host_model.stage(2, 1'b0, REG_LOCK0, ZERO_W);
        u_cms_host_model.stage(3, 1'b0, REG_LOCK0, ZERO_W);
        u_cms_host_model.fire(4'he);
        chk(u_cms_host_model.ans[1], {1'b1, 32'h1});
        chk(u_cms_host_model.ans[2], {1'b1, 32'h0});
        chk(u_cms_host_model.ans[3], {1'b1, 32'h0});
        rd(0, REG_HOLD0, 32'h2);
        end_sim();
    end
endmodule
`default_nettype wire
